//--- cis_sequencer.v
`timescale 1ns/100ps
// Contract
// - cycle runs acquisition, initial sampling, tracking, final sampling in order
// - acquisition lasts exactly the configured number of clocks; code runs one clock when the configured count is zero
// - first acquisition clock clears the integrating capacitor
// - initial point takes oversample-count samples after acquisition
// - final sampling uses same oversample count; both counts configurable
// - cycle length set by strobe timing, not internal count
// - strobe assertion ends tracking and starts final sampling at once; code enters final sampling three clocks after strobe first sampled low
// - continuous mode: next acquisition right after final sampling ends
// - continuous mode: stay tracking until next strobe, one strobe per cycle
// - strobe held beyond oversample count in continuous mode: non-continuous reset
// - continuous mode keeps previous integration rate for next cycle
// - non-continuous mode: new cycle start controlled separately by strobe
// - non-continuous mode resets capacitance at end of each integration
// - strobe held past integration end: hold reset until strobe released
// - strobe held past integration end clears stored integration rate
// - correction selected: result is final minus initial, every cycle; code gives the final point alone when bipolar is set without two's complement
// - correction allowed unipolar any format, bipolar only two's complement
// - unipolar span +full scale down to -1/256 of full scale
// - bipolar span +250 to -251.95 picocoulombs
`include "cis_defines.vh"
module cis_sequencer #(
  parameter DATA_W = `CIS_DATA_W,
  parameter CNT_W  = `CIS_CNT_W,
  parameter RATE_W = `CIS_RATE_W
) (
  input  wire              i_clk,
  input  wire              i_reset_n,
  input  wire [3:0]        i_addr,
  input  wire [31:0]       i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [31:0]       o_rdata,
  input  wire              i_final_sample_start_n,
  input  wire              i_cont_mode,
  input  wire              i_double_sample_correction,
  input  wire [DATA_W-1:0] i_sample,
  input  wire signed [RATE_W-1:0] i_rate,
  output reg               o_cap_reset,
  output reg               o_rate_clear,
  output reg               o_sample_en,
  output reg               o_initial_phase,
  output reg  [2:0]        o_phase,
  output reg  [DATA_W-1:0] o_result,
  output reg               o_result_valid,
  output reg               o_short_int
);

  reg [1:0] rst_sync_q;
  wire      rst_n = rst_sync_q[1];

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // strobe synchroniser, asserted level is low
  reg [2:0] fss_q;
  reg       fss_act_q;
  wire      fss_act_d = (fss_q[2] == fss_q[1]) ? ~fss_q[1] : fss_act_q;
  wire      fss_rise  = fss_act_d & ~fss_act_q;

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fss_q     <= 3'h7;
      fss_act_q <= 1'b0;
    end else begin
      fss_q     <= {fss_q[1:0], i_final_sample_start_n};
      fss_act_q <= fss_act_d;
    end
  end

  reg  [7:0]       ctrl_q;
  reg  [CNT_W-1:0] acq_len_q;
  reg  [CNT_W-1:0] ovs_q;
  wire             cont   = ctrl_q[`CIS_CTRL_CONT] | i_cont_mode;
  wire             dsc_sel = ctrl_q[`CIS_CTRL_DSC] | i_double_sample_correction;
  wire             bip    = ctrl_q[`CIS_CTRL_BIPOLAR];
  wire             twos   = ctrl_q[`CIS_CTRL_TWOS];
  wire             dsc_ok = dsc_sel & (~bip | twos);

  function [CNT_W-1:0] at_least_one;
    input [CNT_W-1:0] v;
    begin
      at_least_one = (v == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : v;
    end
  endfunction

  wire [CNT_W-1:0] k_len = at_least_one(acq_len_q);
  wire [CNT_W-1:0] m_len = at_least_one(ovs_q);

  reg  [2:0]        st_q, st_d;
  reg  [CNT_W-1:0]  cnt_q, cnt_d;
  reg  [31:0]       int_len_q;
  reg  signed [DATA_W+CNT_W-1:0] acc_q, init_q, fin_q;
  reg  signed [RATE_W-1:0] rate_q;
  reg  [31:0]       cycles_q;
  reg               overrun_q;

  wire cnt_last = (cnt_q == {CNT_W{1'b0}});
  wire signed [DATA_W+CNT_W-1:0] samp_ext =
    $signed({{CNT_W{1'b0}}, i_sample});
  wire signed [DATA_W+CNT_W-1:0] diff = fin_q - init_q;
  wire [31:0] tmin = bip ? `CIS_TMIN_BIP_CYC : `CIS_TMIN_UNI_CYC;

  always @* begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      `CIS_ST_IDLE: begin
        if (ctrl_q[`CIS_CTRL_EN] && !fss_act_q) begin
          st_d  = `CIS_ST_ACQ;
          cnt_d = k_len - 1'b1;
        end
      end
      `CIS_ST_ACQ: begin
        if (cnt_last) begin
          st_d  = `CIS_ST_INIT;
          cnt_d = m_len - 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      `CIS_ST_INIT: begin
        if (cnt_last) begin
          st_d = `CIS_ST_TRACK;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      `CIS_ST_TRACK: begin
        if (fss_rise) begin
          st_d  = `CIS_ST_FINAL;
          cnt_d = m_len - 1'b1;
        end
      end
      `CIS_ST_FINAL: begin
        if (cnt_last) begin
          if (cont && !fss_act_d) begin
            st_d  = `CIS_ST_ACQ;
            cnt_d = k_len - 1'b1;
          end else begin
            st_d = `CIS_ST_HOLD;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      `CIS_ST_HOLD: begin
        if (!fss_act_q) begin
          st_d  = `CIS_ST_ACQ;
          cnt_d = k_len - 1'b1;
        end
      end
      default: begin
        st_d  = `CIS_ST_IDLE;
        cnt_d = {CNT_W{1'b0}};
      end
    endcase
  end

  // output levels for the state being entered
  reg cap_reset_d;
  reg rate_clear_d;
  reg sample_en_d;
  reg initial_phase_d;

  always @* begin
    cap_reset_d     = 1'b0;
    rate_clear_d    = 1'b0;
    sample_en_d     = 1'b0;
    initial_phase_d = 1'b0;
    case (st_d)
      `CIS_ST_IDLE: begin
        cap_reset_d  = 1'b1;
        rate_clear_d = 1'b1;
      end
      `CIS_ST_ACQ: begin
        cap_reset_d = (st_q != `CIS_ST_ACQ);
      end
      `CIS_ST_INIT: begin
        sample_en_d     = 1'b1;
        initial_phase_d = 1'b1;
      end
      `CIS_ST_FINAL: begin
        sample_en_d = 1'b1;
      end
      `CIS_ST_HOLD: begin
        // capacitor and rate stay cleared while the strobe is held
        cap_reset_d  = 1'b1;
        rate_clear_d = 1'b1;
      end
      default: begin
        cap_reset_d = 1'b0;
      end
    endcase
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= `CIS_ST_IDLE;
      cnt_q           <= {CNT_W{1'b0}};
      o_cap_reset     <= 1'b1;
      o_rate_clear    <= 1'b1;
      o_sample_en     <= 1'b0;
      o_initial_phase <= 1'b0;
      o_phase         <= `CIS_ST_IDLE;
      int_len_q       <= 32'h0;
    end else begin
      st_q            <= st_d;
      cnt_q           <= cnt_d;
      o_phase         <= st_d;
      o_cap_reset     <= cap_reset_d;
      o_rate_clear    <= rate_clear_d;
      o_sample_en     <= sample_en_d;
      o_initial_phase <= initial_phase_d;
      // integration length from the first acquisition clock after idle or hold; a continuous restart from final keeps counting
      if (st_q == `CIS_ST_ACQ || st_q == `CIS_ST_IDLE || st_q == `CIS_ST_HOLD) begin
        if (st_d == `CIS_ST_ACQ && st_q != `CIS_ST_ACQ) begin
          int_len_q <= 32'h1;
        end else begin
          int_len_q <= int_len_q + 32'h1;
        end
      end else begin
        int_len_q <= int_len_q + 32'h1;
      end
    end
  end

  // tracking rate memory, kept across continuous cycles
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q    <= {RATE_W{1'b0}};
      overrun_q <= 1'b0;
    end else begin
      if (st_q == `CIS_ST_HOLD || st_q == `CIS_ST_IDLE) begin
        rate_q <= {RATE_W{1'b0}};
      end else if (st_q == `CIS_ST_TRACK) begin
        rate_q <= i_rate;
      end
      if (st_q == `CIS_ST_FINAL && st_d == `CIS_ST_HOLD) begin
        overrun_q <= cont;
      end
    end
  end

  // oversample sums for the initial and final points
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q  <= {(DATA_W+CNT_W){1'b0}};
      init_q <= {(DATA_W+CNT_W){1'b0}};
      fin_q  <= {(DATA_W+CNT_W){1'b0}};
    end else begin
      if ((st_q == `CIS_ST_INIT || st_q == `CIS_ST_FINAL) && cnt_q == m_len - 1'b1) begin
        acc_q <= samp_ext;
      end else if (st_q == `CIS_ST_INIT || st_q == `CIS_ST_FINAL) begin
        acc_q <= acc_q + samp_ext;
      end
      if (st_q == `CIS_ST_INIT && cnt_last) begin
        init_q <= (cnt_q == m_len - 1'b1) ? samp_ext : acc_q + samp_ext;
      end
      if (st_q == `CIS_ST_FINAL && cnt_last) begin
        fin_q <= (cnt_q == m_len - 1'b1) ? samp_ext : acc_q + samp_ext;
      end
    end
  end

  // result formatting stage, fed by the completed final point
  reg done_q;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (st_q == `CIS_ST_FINAL) && cnt_last;
    end
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_result <= {DATA_W{1'b0}};
      o_result_valid <= 1'b0;
      o_short_int <= 1'b0;
      cycles_q <= 32'h0;
    end else if (done_q) begin
      o_result       <= dsc_ok ? diff[DATA_W-1:0] : fin_q[DATA_W-1:0];
      o_result_valid <= 1'b1;
      o_short_int    <= (int_len_q < tmin);
      cycles_q       <= cycles_q + 32'h1;
    end else begin
      o_result_valid <= 1'b0;
    end
  end

  // read mux, registered so data stand only in the cycle after the strobe
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0;
    if (i_rd) begin
      case (i_addr)
        `CIS_REG_CTRL:    rdata_d = {24'h0, ctrl_q};
        `CIS_REG_ACQ_LEN: rdata_d = {{(32-CNT_W){1'b0}}, acq_len_q};
        `CIS_REG_OVS:     rdata_d = {{(32-CNT_W){1'b0}}, ovs_q};
        `CIS_REG_STATUS:  rdata_d = {27'h0, overrun_q, dsc_ok, st_q};
        `CIS_REG_RESULT:  rdata_d = {{(32-DATA_W){o_result[DATA_W-1]}}, o_result};
        `CIS_REG_INITPT:  rdata_d = init_q[31:0];
        `CIS_REG_FINALPT: rdata_d = fin_q[31:0];
        `CIS_REG_RATE:    rdata_d = {{(32-RATE_W){rate_q[RATE_W-1]}}, rate_q};
        default:          rdata_d = 32'h0;
      endcase
    end
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= 8'h0;
      acq_len_q <= `CIS_K_RESET;
      ovs_q     <= `CIS_M_RESET;
      o_rdata   <= 32'h0;
    end else begin
      if (i_wr) begin
        case (i_addr)
          `CIS_REG_CTRL:    ctrl_q    <= i_wdata[7:0];
          `CIS_REG_ACQ_LEN: acq_len_q <= i_wdata[CNT_W-1:0];
          `CIS_REG_OVS:     ovs_q     <= i_wdata[CNT_W-1:0];
          default: ;
        endcase
      end
      o_rdata <= rdata_d;
    end
  end

endmodule

//--- cis_defines.vh
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH

`define CIS_ST_IDLE        3'h0
`define CIS_ST_ACQ         3'h1
`define CIS_ST_INIT        3'h2
`define CIS_ST_TRACK       3'h3
`define CIS_ST_FINAL       3'h4
`define CIS_ST_HOLD        3'h5

`define CIS_DATA_W         24
`define CIS_CNT_W          9
`define CIS_K_RESET        9'h010
`define CIS_M_RESET        9'h010
`define CIS_CLK_MHZ        100
`define CIS_TMIN_UNI_US    64
`define CIS_TMIN_BIP_US    32
`define CIS_TMIN_UNI_CYC   (`CIS_TMIN_UNI_US * `CIS_CLK_MHZ)
`define CIS_TMIN_BIP_CYC   (`CIS_TMIN_BIP_US * `CIS_CLK_MHZ)
`define CIS_RATE_W         16

`define CIS_REG_CTRL       4'h0
`define CIS_REG_ACQ_LEN    4'h1
`define CIS_REG_OVS        4'h2
`define CIS_REG_STATUS     4'h3
`define CIS_REG_RESULT     4'h4
`define CIS_REG_INITPT     4'h5
`define CIS_REG_FINALPT    4'h6
`define CIS_REG_RATE       4'h7

`define CIS_CTRL_CONT      0
`define CIS_CTRL_DSC       1
`define CIS_CTRL_BIPOLAR   2
`define CIS_CTRL_TWOS      3
`define CIS_CTRL_EN        4

`endif

//--- cis_strobe_ctl.sv
`timescale 1ns/100ps
module cis_strobe_ctl (
  input  wire       i_clk,
  input  wire       i_fire,
  input  wire [7:0] i_width,
  output reg        o_final_sample_start_n
);
  reg [7:0] left_q;
  initial begin
    left_q = 8'h00;
    o_final_sample_start_n = 1'b1;
  end
  // one low pulse per integration end, only when the bench asks
  always @(posedge i_clk) begin
    if (i_fire) begin
      left_q <= i_width;
      o_final_sample_start_n <= 1'b0;
    end else if (left_q > 8'h01) begin
      left_q <= left_q - 8'h01;
    end else begin
      o_final_sample_start_n <= 1'b1;
    end
  end
endmodule

//--- cis_asserts.sv
`timescale 1ns/100ps
`include "cis_defines.vh"
module cis_asserts #(parameter CNT_W = 9) (
  input wire        i_clk,
  input wire        i_reset_n,
  input wire [3:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_final_sample_start_n,
  input wire        i_cont_mode,
  input wire        o_cap_reset,
  input wire        o_rate_clear,
  input wire [2:0]  o_phase,
  input wire        o_result_valid
);
  reg [CNT_W-1:0] acq_q, ovs_q;
  reg [2:0]       ph_q, lo_q, hi_q;
  reg [15:0]      run_q;
  reg             cont_q;
  wire            ext = o_phase != ph_q;
  wire            cont = cont_q | i_cont_mode;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // shadows of count registers, phase run length, strobe level runs
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acq_q <= `CIS_K_RESET;
      ovs_q <= `CIS_M_RESET;
      cont_q <= 1'b0;
      ph_q <= `CIS_ST_IDLE;
      run_q <= 16'h0000;
      lo_q <= 3'h0;
      hi_q <= 3'h0;
    end else begin
      if (i_wr && i_addr == `CIS_REG_ACQ_LEN) acq_q <= i_wdata[CNT_W-1:0];
      if (i_wr && i_addr == `CIS_REG_OVS) ovs_q <= i_wdata[CNT_W-1:0];
      if (i_wr && i_addr == `CIS_REG_CTRL) cont_q <= i_wdata[`CIS_CTRL_CONT];
      ph_q <= o_phase;
      run_q <= ext ? 16'h0001 : run_q + 16'h0001;
      lo_q <= i_final_sample_start_n ? 3'h0 : lo_q + {2'h0, lo_q != 3'h7};
      hi_q <= !i_final_sample_start_n ? 3'h0 : hi_q + {2'h0, hi_q != 3'h7};
    end
  end
  chk_acq_len: assert property (ph_q == `CIS_ST_ACQ && ext
    |-> run_q == (acq_q == 0 ? 1 : acq_q)) else $error("acquisition length off");
  chk_init_len: assert property (ph_q == `CIS_ST_INIT && ext
    |-> run_q == ovs_q) else $error("initial sample count off");
  chk_final_len: assert property (ph_q == `CIS_ST_FINAL && ext
    |-> run_q == ovs_q) else $error("final sample count off");
  chk_cap_first: assert property (o_phase == `CIS_ST_ACQ && ph_q != `CIS_ST_ACQ
    |-> o_cap_reset) else $error("no capacitor clear on first acquisition clock");
  chk_acq_order: assert property (ph_q == `CIS_ST_ACQ && ext
    |-> o_phase == `CIS_ST_INIT) else $error("acquisition not followed by initial");
  chk_init_order: assert property (ph_q == `CIS_ST_INIT && ext
    |-> o_phase == `CIS_ST_TRACK) else $error("initial not followed by tracking");
  chk_final_go: assert property (o_phase == `CIS_ST_TRACK && $fell(i_final_sample_start_n)
    |-> ##[1:6] o_phase == `CIS_ST_FINAL) else $error("strobe did not start final");
  chk_cont_next: assert property (ph_q == `CIS_ST_FINAL && ext && cont && hi_q >= 3'h5
    |-> o_phase == `CIS_ST_ACQ) else $error("continuous cycle did not restart");
  chk_long_hold: assert property (ph_q == `CIS_ST_FINAL && ext && lo_q == 3'h7
    |-> o_phase == `CIS_ST_HOLD) else $error("held strobe did not reset");
  chk_hold_stay: assert property (o_phase == `CIS_ST_HOLD && lo_q >= 3'h5
    |=> o_phase == `CIS_ST_HOLD) else $error("left reset while strobe held");
  chk_hold_clear: assert property (o_phase == `CIS_ST_HOLD
    |-> o_rate_clear && o_cap_reset) else $error("reset state without clears");
  chk_result_time: assert property (ph_q == `CIS_ST_FINAL && ext
    |=> o_result_valid ##1 !o_result_valid) else $error("result pulse misplaced");
  cover property (ph_q == `CIS_ST_FINAL && o_phase == `CIS_ST_HOLD);
  cover property (ph_q == `CIS_ST_FINAL && o_phase == `CIS_ST_ACQ);
  cover property (o_result_valid);
endmodule
bind cis_sequencer cis_asserts #(.CNT_W(CNT_W)) cis_asserts_inst (.i_clk, .i_reset_n,
  .i_addr, .i_wdata, .i_wr, .i_final_sample_start_n, .i_cont_mode, .o_cap_reset,
  .o_rate_clear, .o_phase, .o_result_valid);

//--- tb.sv
`timescale 1ns/100ps
`include "cis_defines.vh"
module tb;
  reg         i_clk, i_reset_n, i_wr, i_rd, i_cont_mode, i_double_sample_correction, fire;
  reg  [3:0]  i_addr;
  reg  [31:0] i_wdata;
  reg  [23:0] i_sample;
  reg  [15:0] i_rate;
  reg  [7:0]  width;
  wire [31:0] o_rdata;
  wire [23:0] o_result;
  wire [2:0]  o_phase;
  wire        i_final_sample_start_n, o_cap_reset, o_rate_clear, o_result_valid;
  wire        o_sample_en, o_initial_phase, o_short_int;
  integer     fails, check_count, cyc, i;
  localparam [44:0] CFGS = {9'h110, 9'h01E, 9'h016, 9'h01A, 9'h012};
  cis_sequencer cis_sequencer_inst (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_final_sample_start_n, .i_cont_mode, .i_double_sample_correction,
    .i_sample, .i_rate, .o_cap_reset, .o_rate_clear, .o_sample_en, .o_initial_phase,
    .o_phase, .o_result, .o_result_valid, .o_short_int);
  cis_strobe_ctl cis_strobe_ctl_inst (.i_clk, .i_fire(fire), .i_width(width),
    .o_final_sample_start_n(i_final_sample_start_n));
  task results;
    begin
      if (fails == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] exp);
    begin
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
    end
  endtask
  task wait_ph(input [2:0] ph);
    integer n;
    begin
      n = 0;
      #1;
      while (o_phase !== ph && n < 300) begin
        @(posedge i_clk);
        #1 n = n + 1;
      end
      chk(o_phase, ph);
    end
  endtask
  // end the integration with a strobe of w clocks, then take the result
  task cycle(input [7:0] w, input [23:0] exp);
    integer n;
    begin
      @(posedge i_clk);
      fire <= 1'b1;
      width <= w;
      @(posedge i_clk);
      fire <= 1'b0;
      n = 0;
      #1;
      while (o_result_valid !== 1'b1 && n < 300) begin
        @(posedge i_clk);
        #1 n = n + 1;
      end
      chk(o_result, exp);
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      results;
    end
  end
  initial begin
    {i_reset_n, i_wr, i_rd, i_cont_mode, i_double_sample_correction, fire} = 6'h00;
    {i_addr, i_wdata, width, i_rate} = 60'h0;
    i_rate = 16'h1234;
    i_sample = 24'h000011;
    {fails, check_count, cyc} = 96'h0;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(`CIS_REG_ACQ_LEN, 32'h10);
    rd(`CIS_REG_OVS, 32'h10);
    wr(`CIS_REG_ACQ_LEN, 32'h3);
    wr(`CIS_REG_OVS, 32'h4);
    wr(4'hF, 32'hFFFFFFFF);
    rd(`CIS_REG_ACQ_LEN, 32'h3);
    rd(`CIS_REG_OVS, 32'h4);
    rd(4'hF, 32'h0);
    wr(`CIS_REG_CTRL, 32'h10);
    wait_ph(`CIS_ST_TRACK);
    cycle(8'h02, 24'h44);
    chk(o_short_int, 1'b1);
    wait_ph(`CIS_ST_TRACK);
    for (i = 0; i < 5; i = i + 1) begin
      i_cont_mode <= 1'b1;
      i_double_sample_correction <= CFGS[i*9+8];
      wr(`CIS_REG_CTRL, {24'h0, CFGS[i*9 +: 8]});
      wait_ph(`CIS_ST_TRACK);
      cycle(8'h02, i == 2 ? 24'h44 : 24'h0);
      chk(o_phase, `CIS_ST_ACQ);
      chk(o_rate_clear, 1'b0);
      chk(o_sample_en, 1'b0);
      chk(o_initial_phase, 1'b0);
      rd(`CIS_REG_RATE, 32'h1234);
      chk(o_initial_phase, 1'b1);
      chk(o_sample_en, 1'b1);
    end
    wait_ph(`CIS_ST_TRACK);
    cycle(8'h14, 24'h0);
    chk(o_phase, `CIS_ST_HOLD);
    chk(o_rate_clear, 1'b1);
    repeat (5) @(posedge i_clk);
    #1 chk(o_phase, `CIS_ST_HOLD);
    rd(`CIS_REG_RATE, 32'h0);
    wait_ph(`CIS_ST_ACQ);
    i_cont_mode <= 1'b0;
    i_double_sample_correction <= 1'b0;
    wr(`CIS_REG_CTRL, 32'h10);
    wait_ph(`CIS_ST_TRACK);
    cycle(8'h02, 24'h44);
    wait_ph(`CIS_ST_ACQ);
    results;
  end
endmodule
